// *** gpio_ports_de.sv ***
// Eight-bit and four-bit GPIO ports with direction and analog select, APB slave
//
// Summary of operation
// - Port D direction 1 tri-states, 0 drives
// - Driven pin shows output latch bit
// - Port D analog bit selects analog input
// - Port E analog bits 2-0 control pins
// - Analog-selected pins read back as zero
// - Direction still gates drivers on analog pins
// - Analog pin with direction clear still outputs
// - Port read returns pins; write hits latch
// - Port write is read-modify-write of pins
// - Port E bit 3 input-only, direction reads 1
// - Input-only pin reads 0 when master-clear set
// - Port E direction bits 2-0 control drivers
// - Unimplemented upper bits read as zero
// - Reduced variant port registers absent, read zero, except port E bit 3 pin and its forced direction bit
// - Port D pins selectable as sensing channels
`include "gpio_de_cfg.svh"

module gpio_ports_de (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Port D pins
	input  wire logic [7:0]  d_pin_in,
	output logic      [7:0]  d_pin_out,
	output logic      [7:0]  d_pin_oe_n,
	// Port E pins, bit 3 input-only
	input  wire logic [3:0]  e_pin_in,
	output logic      [2:0]  e_pin_out,
	output logic      [2:0]  e_pin_oe_n,
	// Analog and sensing routing to the analog blocks
	output logic      [7:0]  d_analog_en,
	output logic      [2:0]  e_analog_en,
	output logic      [7:0]  capacitive_sense_channel
);

	// ----------------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------------
	logic [7:0]  d_dir_ff;           // Port D direction
	logic [7:0]  d_ana_ff;           // Port D analog select
	logic [7:0]  d_lat_ff;           // Port D output latch
	logic [2:0]  e_dir_ff;           // Port E direction, bits 2-0
	logic [2:0]  e_ana_ff;           // Port E analog select
	logic [2:0]  e_lat_ff;           // Port E output latch
	logic [2:0]  set_ff;             // Settings: sense, reduced, master-clear
	logic [7:0]  nxt_d_dir;
	logic [7:0]  nxt_d_ana;
	logic [7:0]  nxt_d_lat;
	logic [2:0]  nxt_e_dir;
	logic [2:0]  nxt_e_ana;
	logic [2:0]  nxt_e_lat;
	logic [2:0]  nxt_set;
	// Bus response state
	logic [31:0] prdata_ff;          // Registered read data
	logic        pready_ff;          // Registered ready
	logic        pslverr_ff;         // Registered error
	logic [31:0] nxt_prdata;
	logic        nxt_pready;
	logic        nxt_pslverr;
	// Pin output state
	logic [7:0]  d_out_ff;
	logic [7:0]  d_oe_n_ff;
	logic [2:0]  e_out_ff;
	logic [2:0]  e_oe_n_ff;
	logic [7:0]  d_aen_ff;
	logic [2:0]  e_aen_ff;
	logic [7:0]  sense_ff;
	logic [7:0]  nxt_d_out;
	logic [7:0]  nxt_d_oe_n;
	logic [2:0]  nxt_e_out;
	logic [2:0]  nxt_e_oe_n;
	logic [7:0]  nxt_d_aen;
	logic [2:0]  nxt_e_aen;
	logic [7:0]  nxt_sense;

	// ----------------------------------------------------------------------
	// Synchronised pin levels and digital read views
	// ----------------------------------------------------------------------
	logic [7:0]  d_pin_sync;         // Filtered port D pins
	logic [3:0]  e_pin_sync;         // Filtered port E pins
	logic [7:0]  d_read;             // Port D as software sees it
	logic [3:0]  e_read;             // Port E as software sees it
	logic        reduced;            // Reduced variant, settings register bit
	gpio_de_pkg::reg_sel_t sel;      // Decoded register

	// Pins come from the board, so they are synchronised first
	gpio_pin_sync #(
		.WIDTH     (8)
	) u_sync_d (
		.clk       (clk),
		.rst_n     (rst_n),
		.raw_in    (d_pin_in),
		.level_out (d_pin_sync)
	);

	gpio_pin_sync #(
		.WIDTH     (4)
	) u_sync_e (
		.clk       (clk),
		.rst_n     (rst_n),
		.raw_in    (e_pin_in),
		.level_out (e_pin_sync)
	);

	// ----------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------
	// Address decode, used for both read and write paths
	function automatic gpio_de_pkg::reg_sel_t decode(input logic [11:0] a);
		case (a)
			`OFS_PORT_D_DATA:      decode = gpio_de_pkg::SEL_D_DATA;
			`OFS_PORT_D_DIRECTION: decode = gpio_de_pkg::SEL_D_DIR;
			`OFS_PORT_D_ANALOG:    decode = gpio_de_pkg::SEL_D_ANALOG;
			`OFS_PORT_E_DATA:      decode = gpio_de_pkg::SEL_E_DATA;
			`OFS_PORT_E_DIRECTION: decode = gpio_de_pkg::SEL_E_DIR;
			`OFS_PORT_E_ANALOG:    decode = gpio_de_pkg::SEL_E_ANALOG;
			`OFS_PORT_SETTINGS:    decode = gpio_de_pkg::SEL_SETTINGS;
			default:               decode = gpio_de_pkg::SEL_NONE;
		endcase
	endfunction
	// Byte-lane 0 merge; only the low lane carries register bits
	function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] wd,
	                                     input logic [3:0] st);
		lane0 = st[0] ? wd[7:0] : old;
	endfunction
	assign sel     = decode(paddr);
	assign reduced = set_ff[`SET_REDUCED_BIT];
	// Digital read views: analog pins read zero, input-only pin masked by master-clear
	always_comb begin
		d_read = d_pin_sync & ~d_ana_ff;
		e_read = {e_pin_sync[3], e_pin_sync[2:0] & ~e_ana_ff};
		if (set_ff[`SET_MCLR_BIT]) begin
			e_read[`E_INPUT_ONLY_BIT] = 1'b0;
		end
		if (reduced) begin
			d_read      = '0;
			e_read[2:0] = '0;
		end
	end

	// ----------------------------------------------------------------------
	// Register write path
	// ----------------------------------------------------------------------
	// Writes take effect in the access phase; ready is always immediate
	always_comb begin
		logic wr;
		logic [7:0] rmw;
		wr        = psel & penable & pwrite;
		rmw       = 8'h00;
		nxt_d_dir = d_dir_ff;
		nxt_d_ana = d_ana_ff;
		nxt_d_lat = d_lat_ff;
		nxt_e_dir = e_dir_ff;
		nxt_e_ana = e_ana_ff;
		nxt_e_lat = e_lat_ff;
		nxt_set   = set_ff;
		if (wr) begin
			case (sel)
				gpio_de_pkg::SEL_D_DATA: begin
					// Pins sampled, addressed lane modified, whole latch stored
					rmw = lane0(d_read, pwdata, pstrb);
					if (!reduced) begin
						nxt_d_lat = rmw;
					end
				end
				gpio_de_pkg::SEL_D_DIR: begin
					if (!reduced) begin
						nxt_d_dir = lane0(d_dir_ff, pwdata, pstrb);
					end
				end
				gpio_de_pkg::SEL_D_ANALOG: begin
					if (!reduced) begin
						nxt_d_ana = lane0(d_ana_ff, pwdata, pstrb);
					end
				end
				gpio_de_pkg::SEL_E_DATA: begin
					// Bit 3 is read-only, so only the low three reach the latch
					rmw = lane0({4'h0, e_read}, pwdata, pstrb);
					if (!reduced) begin
						nxt_e_lat = rmw[2:0];
					end
				end
				gpio_de_pkg::SEL_E_DIR: begin
					rmw = lane0({5'h00, e_dir_ff}, pwdata, pstrb);
					if (!reduced) begin
						nxt_e_dir = rmw[2:0];
					end
				end
				gpio_de_pkg::SEL_E_ANALOG: begin
					rmw = lane0({5'h00, e_ana_ff}, pwdata, pstrb);
					if (!reduced) begin
						nxt_e_ana = rmw[2:0];
					end
				end
				gpio_de_pkg::SEL_SETTINGS: begin
					rmw     = lane0({5'h00, set_ff}, pwdata, pstrb);
					nxt_set = rmw[2:0];
				end
				default: begin
					rmw = 8'h00;
				end
			endcase
		end
	end

	// Register bank; latches have no defined reset value, cleared here for determinism
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			d_dir_ff <= `RST_DIRECTION;
			d_ana_ff <= `RST_ANALOG;
			d_lat_ff <= `RST_LATCH;
			e_dir_ff <= 3'h7;
			e_ana_ff <= 3'h7;
			e_lat_ff <= 3'h0;
			set_ff   <= 3'h0;
		end else begin
			d_dir_ff <= nxt_d_dir;
			d_ana_ff <= nxt_d_ana;
			d_lat_ff <= nxt_d_lat;
			e_dir_ff <= nxt_e_dir;
			e_ana_ff <= nxt_e_ana;
			e_lat_ff <= nxt_e_lat;
			set_ff   <= nxt_set;
		end
	end

	// ----------------------------------------------------------------------
	// Register read path and bus response
	// ----------------------------------------------------------------------
	// Answer in the first access cycle; unmapped addresses get pslverr
	always_comb begin
		logic [7:0] rd;
		rd          = 8'h00;
		nxt_pready  = 1'b0;
		nxt_pslverr = 1'b0;
		nxt_prdata  = prdata_ff;
		if (psel && !penable) begin
			nxt_pready = 1'b1;
			case (sel)
				gpio_de_pkg::SEL_D_DATA:   rd = d_read;
				gpio_de_pkg::SEL_D_DIR:    rd = reduced ? 8'h00 : d_dir_ff;
				gpio_de_pkg::SEL_D_ANALOG: rd = reduced ? 8'h00 : d_ana_ff;
				gpio_de_pkg::SEL_E_DATA:   rd = {4'h0, e_read};
				gpio_de_pkg::SEL_E_DIR: begin
					// Input-only pin's direction always reads one
					rd = `E_DIR_FORCED | (reduced ? 8'h00 : {5'h00, e_dir_ff});
				end
				gpio_de_pkg::SEL_E_ANALOG: rd = reduced ? 8'h00 : {5'h00, e_ana_ff};
				gpio_de_pkg::SEL_SETTINGS: rd = {5'h00, set_ff};
				default: begin
					rd          = 8'h00;
					nxt_pslverr = 1'b1;
				end
			endcase
			nxt_prdata = {24'h000000, rd};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_ff  <= 32'h00000000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// ----------------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------------
	// Drivers follow direction, all off in reduced mode; analog select never gates them
	always_comb begin
		nxt_d_out  = d_lat_ff;
		nxt_d_oe_n = d_dir_ff;
		nxt_e_out  = e_lat_ff;
		nxt_e_oe_n = e_dir_ff;
		nxt_d_aen  = d_ana_ff;
		nxt_e_aen  = e_ana_ff;
		// Sensing channel needs the pin tri-stated and analog
		nxt_sense  = set_ff[`SET_SENSE_BIT] ? (d_ana_ff & d_dir_ff) : 8'h00;
		if (reduced) begin
			nxt_d_oe_n = 8'hFF;
			nxt_e_oe_n = 3'h7;
			nxt_d_aen  = 8'h00;
			nxt_e_aen  = 3'h0;
			nxt_sense  = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			d_out_ff  <= 8'h00;
			d_oe_n_ff <= 8'hFF;
			e_out_ff  <= 3'h0;
			e_oe_n_ff <= 3'h7;
			d_aen_ff  <= 8'hFF;
			e_aen_ff  <= 3'h7;
			sense_ff  <= 8'h00;
		end else begin
			d_out_ff  <= nxt_d_out;
			d_oe_n_ff <= nxt_d_oe_n;
			e_out_ff  <= nxt_e_out;
			e_oe_n_ff <= nxt_e_oe_n;
			d_aen_ff  <= nxt_d_aen;
			e_aen_ff  <= nxt_e_aen;
			sense_ff  <= nxt_sense;
		end
	end

	// Output assignments, each straight from its flip-flop
	assign prdata                   = prdata_ff;
	assign pready                   = pready_ff;
	assign pslverr                  = pslverr_ff;
	assign d_pin_out                = d_out_ff;
	assign d_pin_oe_n               = d_oe_n_ff;
	assign e_pin_out                = e_out_ff;
	assign e_pin_oe_n               = e_oe_n_ff;
	assign d_analog_en              = d_aen_ff;
	assign e_analog_en              = e_aen_ff;
	assign capacitive_sense_channel = sense_ff;

endmodule

// *** gpio_de_cfg.svh ***
// Register offsets, field positions, reset values and widths for the two-port GPIO block
`ifndef GPIO_DE_CFG_SVH
`define GPIO_DE_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the APB bus
// ----------------------------------------------------------------------
`define OFS_PORT_D_DATA       12'h000
`define OFS_PORT_D_DIRECTION  12'h004
`define OFS_PORT_D_ANALOG     12'h008
`define OFS_PORT_E_DATA       12'h00C
`define OFS_PORT_E_DIRECTION  12'h010
`define OFS_PORT_E_ANALOG     12'h014
`define OFS_PORT_SETTINGS     12'h018

// ----------------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------------
`define RST_DIRECTION         8'hFF
`define RST_ANALOG            8'hFF
`define RST_LATCH             8'h00
`define E_DATA_MASK           8'h0F
`define E_DIR_MASK            8'h07
`define E_ANALOG_MASK         8'h07
`define E_DIR_FORCED          8'h08
`define E_INPUT_ONLY_BIT      3
`define SET_MCLR_BIT          0
`define SET_REDUCED_BIT       1
`define SET_SENSE_BIT         2

`endif

// *** gpio_de_pkg.sv ***
// Types shared by the two-port GPIO block
package gpio_de_pkg;

	// ----------------------------------------------------------------------
	// Register selector decoded from the APB address
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {
		SEL_D_DATA,
		SEL_D_DIR,
		SEL_D_ANALOG,
		SEL_E_DATA,
		SEL_E_DIR,
		SEL_E_ANALOG,
		SEL_SETTINGS,
		SEL_NONE
	} reg_sel_t;

endpackage

// *** gpio_pin_sync.sv ***
// Three-stage pin synchroniser with second/third-stage agreement filter
module gpio_pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Raw pin levels and filtered result
	input  wire logic [WIDTH-1:0] raw_in,
	output logic      [WIDTH-1:0] level_out
);

	// ----------------------------------------------------------------------
	// Synchroniser stages
	// ----------------------------------------------------------------------
	logic [WIDTH-1:0] meta_ff;       // First stage, read only by second
	logic [WIDTH-1:0] sync2_ff;      // Second stage
	logic [WIDTH-1:0] sync3_ff;      // Third stage
	logic [WIDTH-1:0] level_ff;      // Accepted level
	logic [WIDTH-1:0] nxt_level;     // Next accepted level

	// Accept a bit only when stages two and three agree; filters one-cycle glitches
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			nxt_level[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : level_ff[i];
		end
	end

	// Register all stages
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff  <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
			level_ff <= '0;
		end else begin
			meta_ff  <= raw_in;
			sync2_ff <= meta_ff;
			sync3_ff <= sync2_ff;
			level_ff <= nxt_level;
		end
	end

	assign level_out = level_ff;

endmodule

// *** gpio_ports_de_monitor.sv ***
// Checker of the two-port GPIO block, attached by bind to its top module
`include "gpio_de_cfg.svh"
module gpio_ports_de_monitor (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// APB side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pin side
	input wire logic [7:0]  d_pin_out,
	input wire logic [7:0]  d_pin_oe_n,
	input wire logic [2:0]  e_pin_oe_n,
	input wire logic [7:0]  d_analog_en
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Settings shadow
	// ----------------------------------------
	logic [2:0] set_ff;  // Copy of the settings register
	logic [2:0] nxt_set; // Its next value
	logic       done;    // Transfer ends this cycle
	logic       wr;      // Port write that must land
	logic       rd;      // Read ends this cycle
	assign done = psel && penable && pready;
	assign wr   = done && pwrite && pstrb[0] && !set_ff[1];
	assign rd   = done && !pwrite;
	// Track settings, since reduced mode swallows port writes
	always_comb begin
		nxt_set = set_ff;
		if (done && pwrite && pstrb[0] && paddr == `OFS_PORT_SETTINGS) begin
			nxt_set = pwdata[2:0];
		end
	end
	// Register the shadow
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			set_ff <= 3'h0;
		end else begin
			set_ff <= nxt_set;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	AST_READY_NOWAIT: assert property (setup_s ##1 access_s |-> pready)
		else $error("no ready in first access cycle");
	AST_D_DRIVE: assert property (
		wr && paddr == `OFS_PORT_D_DIRECTION |=> ##1 d_pin_oe_n == $past(pwdata[7:0], 2))
		else $error("port d drivers differ from direction");
	AST_D_LATCH: assert property (
		wr && paddr == `OFS_PORT_D_DATA |=> ##1 d_pin_out == $past(pwdata[7:0], 2))
		else $error("port d latch differs from write");
	AST_D_ANALOG: assert property (
		wr && paddr == `OFS_PORT_D_ANALOG |=> ##1 d_analog_en == $past(pwdata[7:0], 2))
		else $error("port d analog routing differs from write");
	AST_E_DRIVE: assert property (
		wr && paddr == `OFS_PORT_E_DIRECTION |=> ##1 e_pin_oe_n == $past(pwdata[2:0], 2))
		else $error("port e drivers differ from direction");
	AST_E_DIR_READ: assert property (
		rd && paddr == `OFS_PORT_E_DIRECTION |-> prdata[31:3] == 29'h1)
		else $error("port e direction upper bits wrong");
	AST_E_ANALOG_READ: assert property (
		rd && paddr == `OFS_PORT_E_ANALOG |-> prdata[31:3] == 29'h0)
		else $error("port e analog upper bits not zero");
	AST_ANALOG_ZERO: assert property (
		rd && paddr == `OFS_PORT_D_DATA && $stable(d_analog_en)
		&& d_analog_en == $past(d_analog_en, 2) |-> (prdata[7:0] & d_analog_en) == 8'h00)
		else $error("analog pin read back nonzero");
	AST_INPUT_ONLY_CLEAR: assert property (
		rd && set_ff[0] && paddr == `OFS_PORT_E_DATA |-> !prdata[3])
		else $error("input-only pin not zero with master clear");
	AST_REDUCED_ZERO: assert property (
		rd && set_ff[1] && paddr <= `OFS_PORT_D_ANALOG |-> prdata == 32'h0)
		else $error("absent port d register read nonzero");
endmodule

bind gpio_ports_de gpio_ports_de_monitor u_gpio_ports_de_monitor (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .d_pin_out(d_pin_out), .d_pin_oe_n(d_pin_oe_n),
	.e_pin_oe_n(e_pin_oe_n), .d_analog_en(d_analog_en)
);

// *** board_model.sv ***
// Board model resolving every port pin from device drivers and board sources
module board_model (
	// Device drivers, low enable drives
	input wire logic [7:0] d_pin_out,
	input wire logic [7:0] d_pin_oe_n,
	input wire logic [2:0] e_pin_out,
	input wire logic [2:0] e_pin_oe_n,
	// Board sources from the bench
	input wire logic [7:0] d_ext,
	input wire logic [3:0] e_ext,
	// Levels seen by the device
	output logic     [7:0] d_pin_in,
	output logic     [3:0] e_pin_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// Driver wins; a released pin follows the board, never the last driven value
	assign d_pin_in = (d_pin_oe_n & d_ext) | (~d_pin_oe_n & d_pin_out);
	assign e_pin_in[2:0] = (e_pin_oe_n & e_ext[2:0]) | (~e_pin_oe_n & e_pin_out);
	// Input-only pin is set by the board alone
	assign e_pin_in[3] = e_ext[3];
endmodule

// *** gpio_ports_d_e_analog_select_bench.sv ***
// Self-checking bench of the two-port GPIO block with a board model
module gpio_ports_d_e_analog_select_bench;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk;         // Core clock
	logic        rst_n;       // Reset, active low
	logic        psel;        // APB select
	logic        penable;     // APB enable
	logic        pwrite;      // APB direction
	logic [11:0] paddr;       // APB address
	logic [31:0] pwdata;      // APB write data
	logic [3:0]  pstrb;       // APB strobes
	logic [31:0] prdata;      // APB read data
	logic        pready;      // APB ready
	logic        pslverr;     // APB error
	logic [7:0]  d_pin_in;    // Resolved port d pins
	logic [7:0]  d_pin_out;   // Port d latch
	logic [7:0]  d_pin_oe_n;  // Port d drivers
	logic [3:0]  e_pin_in;    // Resolved port e pins
	logic [2:0]  e_pin_out;   // Port e latch
	logic [2:0]  e_pin_oe_n;  // Port e drivers
	logic [7:0]  d_analog_en; // Port d analog routing
	logic [2:0]  e_analog_en; // Port e analog routing
	logic [7:0]  sense;       // Sensing channels
	logic [7:0]  d_ext;       // Board level on port d
	logic [3:0]  e_ext;       // Board level on port e
	logic [31:0] rd;          // Last read data
	logic        er;          // Last error flag
	int          fail_count;  // Mismatches
	int          check_count; // Comparisons
	// One access with the board levels it runs under
	typedef struct {
		logic [11:0] a;
		logic        w;
		logic [7:0]  wd;
		logic [7:0]  dx;
		logic [3:0]  ex;
		logic [7:0]  x;
		logic        e;
	} row_t;
	// Address, write, data, board d, board e, expected read, expected error
	row_t rows [29] = '{
		'{12'h004, 1'h0, 8'h00, 8'h00, 4'h0, 8'hFF, 1'h0}, '{12'h008, 1'h0, 8'h00, 8'h00, 4'h0, 8'hFF, 1'h0},
		'{12'h010, 1'h0, 8'h00, 8'h00, 4'h0, 8'h0F, 1'h0}, '{12'h014, 1'h0, 8'h00, 8'h00, 4'h0, 8'h07, 1'h0},
		'{12'h000, 1'h0, 8'h00, 8'hAA, 4'hF, 8'h00, 1'h0}, '{12'h00C, 1'h0, 8'h00, 8'hAA, 4'hF, 8'h08, 1'h0},
		'{12'h008, 1'h1, 8'h00, 8'h5A, 4'hF, 8'h00, 1'h0}, '{12'h000, 1'h0, 8'h00, 8'h5A, 4'hF, 8'h5A, 1'h0},
		'{12'h000, 1'h1, 8'h3C, 8'h5A, 4'hF, 8'h00, 1'h0}, '{12'h000, 1'h0, 8'h00, 8'h5A, 4'hF, 8'h5A, 1'h0},
		'{12'h004, 1'h1, 8'h0F, 8'h5A, 4'hF, 8'h00, 1'h0}, '{12'h000, 1'h0, 8'h00, 8'h5A, 4'hF, 8'h3A, 1'h0},
		'{12'h008, 1'h1, 8'hF0, 8'h5A, 4'hF, 8'h00, 1'h0}, '{12'h000, 1'h0, 8'h00, 8'h5A, 4'hF, 8'h0A, 1'h0},
		'{12'h014, 1'h1, 8'h00, 8'h5A, 4'h0, 8'h00, 1'h0}, '{12'h010, 1'h1, 8'hF8, 8'h5A, 4'h0, 8'h00, 1'h0},
		'{12'h010, 1'h0, 8'h00, 8'h5A, 4'h0, 8'h08, 1'h0}, '{12'h00C, 1'h1, 8'hFF, 8'h5A, 4'h0, 8'h00, 1'h0},
		'{12'h00C, 1'h0, 8'h00, 8'h5A, 4'h0, 8'h07, 1'h0}, '{12'h00C, 1'h0, 8'h00, 8'h5A, 4'h8, 8'h0F, 1'h0},
		'{12'h018, 1'h1, 8'h01, 8'h5A, 4'h8, 8'h00, 1'h0}, '{12'h00C, 1'h0, 8'h00, 8'h5A, 4'h8, 8'h07, 1'h0},
		'{12'h018, 1'h1, 8'h02, 8'h5A, 4'h8, 8'h00, 1'h0}, '{12'h004, 1'h0, 8'h00, 8'h5A, 4'h8, 8'h00, 1'h0},
		'{12'h004, 1'h1, 8'hFF, 8'h5A, 4'h8, 8'h00, 1'h0}, '{12'h018, 1'h1, 8'h00, 8'h5A, 4'h8, 8'h00, 1'h0},
		'{12'h004, 1'h0, 8'h00, 8'h5A, 4'h8, 8'h0F, 1'h0}, '{12'h01C, 1'h0, 8'h00, 8'h5A, 4'h8, 8'h00, 1'h1},
		'{12'h020, 1'h1, 8'h55, 8'h5A, 4'h8, 8'h00, 1'h1}};
	// ----------------------------------------
	// Design and board
	// ----------------------------------------
	gpio_ports_de u_gpio_ports_de (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .d_pin_in(d_pin_in), .d_pin_out(d_pin_out),
		.d_pin_oe_n(d_pin_oe_n), .e_pin_in(e_pin_in), .e_pin_out(e_pin_out),
		.e_pin_oe_n(e_pin_oe_n), .d_analog_en(d_analog_en), .e_analog_en(e_analog_en),
		.capacitive_sense_channel(sense));
	board_model u_board_model (
		.d_pin_out(d_pin_out), .d_pin_oe_n(d_pin_oe_n), .e_pin_out(e_pin_out),
		.e_pin_oe_n(e_pin_oe_n), .d_ext(d_ext), .e_ext(e_ext), .d_pin_in(d_pin_in),
		.e_pin_in(e_pin_in));
	// Free-running clock
	always #2.5 clk = ~clk;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Verdict and end of run
	task automatic stop_test();
		if (fail_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Compare one value
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, x, g);
		end
	endtask
	// One APB transfer; waits for ready, bounded
	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic s);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		pstrb <= {3'h0, s};
		@(posedge clk);
		penable <= 1'h1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'h1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n == 20) begin
			fail_count++;
			stop_test();
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{clk, rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{d_ext, e_ext, fail_count, check_count} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		// Table rows; eight cycles cover pin resolve and the synchroniser
		foreach (rows[i]) begin
			@(posedge clk);
			d_ext <= rows[i].dx;
			e_ext <= rows[i].ex;
			repeat (8) @(posedge clk);
			apb(rows[i].a, rows[i].w, rows[i].wd, 1'h1);
			chk("pslverr", {31'h0, rows[i].e}, {31'h0, er});
			if (rows[i].w == 1'h0) begin
				chk("prdata", {24'h0, rows[i].x}, rd);
			end
		end
		// Unstrobed write stores pin reads, analog bits as zero
		apb(12'h000, 1'h1, 8'hFF, 1'h0);
		apb(12'h004, 1'h1, 8'h00, 1'h1);
		repeat (3) @(posedge clk);
		chk("d_pin_out", 32'h0A, {24'h0, d_pin_out});
		chk("d_pin_oe_n", 32'h00, {24'h0, d_pin_oe_n});
		chk("d_analog_en", 32'hF0, {24'h0, d_analog_en});
		// Reset in mid-run
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		chk("d_pin_oe_n", 32'hFF, {24'h0, d_pin_oe_n});
		chk("e_pin_oe_n", 32'h07, {29'h0, e_pin_oe_n});
		chk("e_analog_en", 32'h07, {29'h0, e_analog_en});
		rst_n <= 1'h1;
		// Sensing channels follow the analog bits, with direction left all tri-stated
		apb(12'h018, 1'h1, 8'h04, 1'h1);
		repeat (4) @(posedge clk);
		chk("sense", 32'hFF, {24'h0, sense});
		apb(12'h008, 1'h1, 8'h0F, 1'h1);
		repeat (4) @(posedge clk);
		chk("sense", 32'h0F, {24'h0, sense});
		stop_test();
	end
endmodule
